// file: hdl/rsq_top.sv
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module rsq_top
    import rsq_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               clk_en,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               rst_pin_i,
    output logic                    rst_pin_o,
    output logic                    rst_pin_oe,
    input  wire logic               wdg_underflow,
    input  wire logic               below_rise_i,
    input  wire logic               below_fall_i,
    input  wire rsq_opt_t           opt_i,
    input  wire logic               osc_tick,
    output logic [1:0]              thr_sel,
    output logic [SRC_NUM-1:0]      osc_en,
    output logic                    mult_on,
    output logic                    mult_bad,
    output logic                    core_tick,
    output logic                    core_rst_n,
    output logic                    vec_fetch,
    output logic [15:0]             vec_addr
);

    rsq_state_t             st_q;
    rsq_state_t             st_d;
    rsq_opt_t               opt_s1;
    rsq_opt_t               opt_s2;
    rsq_opt_t               opt_q;
    logic                   catch_q;
    logic                   ext_s1;
    logic                   ext_s2;
    logic                   pin_s1;
    logic                   pin_s2;
    logic                   rise_s1;
    logic                   rise_s2;
    logic                   fall_s1;
    logic                   fall_s2;
    logic                   armed_q;
    logic                   supply_low_q;
    logic [CNT_W-1:0]       act_cnt_q;
    logic [CNT_W-1:0]       dly_cnt_q;
    logic                   fidx_q;
    logic                   supply_flag_q;
    logic                   wdg_flag_q;
    logic                   ext_req;
    logic                   act_done;
    logic                   dly_done;
    logic                   wr_acc;

    localparam logic [CNT_W-1:0] ACT_LAST = CNT_W'(MIN_RST_OUT_CYC - 1);

    // delay length for the latched option
    function automatic logic [CNT_W-1:0] delay_len(input logic long_sel);
        return long_sel ? CNT_W'(DELAY_LONG_CYC) : CNT_W'(DELAY_SHORT_CYC);
    endfunction

    // pin caught asynchronously so halt with a stopped clock still resets
    always_ff @(posedge pclk or negedge rst_pin_i) begin
        if (!rst_pin_i) begin
            catch_q <= 1'b1;
        end else if (clk_en && st_q != RSQ_RUN) begin
            catch_q <= 1'b0;
        end
    end

    // synchronisers for the caught pin, pin level, comparators, straps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1  <= 1'b0;
            ext_s2  <= 1'b0;
            pin_s1  <= 1'b0;
            pin_s2  <= 1'b0;
            rise_s1 <= 1'b0;
            rise_s2 <= 1'b0;
            fall_s1 <= 1'b0;
            fall_s2 <= 1'b0;
            opt_s1  <= OPT_RST;
            opt_s2  <= OPT_RST;
        end else if (clk_en) begin
            ext_s1  <= catch_q;
            ext_s2  <= ext_s1;
            pin_s1  <= rst_pin_i;
            pin_s2  <= pin_s1;
            rise_s1 <= below_rise_i;
            rise_s2 <= rise_s1;
            fall_s1 <= below_fall_i;
            fall_s2 <= fall_s1;
            opt_s1  <= opt_i;
            opt_s2  <= opt_s1;
        end
    end

    // arm only once the stale catch from our own drive has drained
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q <= 1'b0;
        end else if (clk_en) begin
            armed_q <= (st_q == RSQ_RUN) && (armed_q || !ext_s2);
        end
    end

    assign ext_req = armed_q && ext_s2;

    // supply level with hysteresis; a disabled detector never asserts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_low_q <= 1'b0;
        end else if (clk_en) begin
            if (!opt_s2.det_en) begin
                supply_low_q <= 1'b0;
            end else if (supply_low_q) begin
                supply_low_q <= rise_s2;
            end else begin
                supply_low_q <= fall_s2;
            end
        end
    end

    assign act_done = (act_cnt_q == ACT_LAST);
    assign dly_done = (dly_cnt_q == CNT_W'(1));

    // next state
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            RSQ_ACTIVE: begin
                if (act_done && !supply_low_q) begin
                    st_d = RSQ_DELAY;
                end
            end
            RSQ_DELAY: begin
                if (supply_low_q) begin
                    st_d = RSQ_ACTIVE;
                end else if (core_tick && dly_done) begin
                    st_d = RSQ_RELEASE;
                end
            end
            RSQ_RELEASE: begin
                if (supply_low_q) begin
                    st_d = RSQ_ACTIVE;
                end else if (pin_s2) begin
                    st_d = RSQ_FETCH;
                end
            end
            RSQ_FETCH: begin
                if (supply_low_q) begin
                    st_d = RSQ_ACTIVE;
                end else if (fidx_q) begin
                    st_d = RSQ_RUN;
                end
            end
            RSQ_RUN: begin
                if (supply_low_q || wdg_underflow || ext_req) begin
                    st_d = RSQ_ACTIVE;
                end
            end
        endcase
    end

    // sequencer state and pin drive; pin low in active and delay phases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= RSQ_ACTIVE;
            rst_pin_oe <= 1'b1;
            rst_pin_o  <= 1'b0;
        end else if (clk_en) begin
            st_q       <= st_d;
            rst_pin_oe <= (st_d == RSQ_ACTIVE) || (st_d == RSQ_DELAY);
            rst_pin_o  <= 1'b0;
        end
    end

    // active phase width, at least the minimum output width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_cnt_q <= '0;
        end else if (clk_en) begin
            if (st_q != RSQ_ACTIVE) begin
                act_cnt_q <= '0;
            end else if (!act_done) begin
                act_cnt_q <= act_cnt_q + CNT_W'(1);
            end
        end
    end

    // delay counts cpu cycles only once the active phase is over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_cnt_q <= '0;
        end else if (clk_en) begin
            if (st_q == RSQ_ACTIVE) begin
                dly_cnt_q <= delay_len(opt_s2.delay_long);
            end else if (st_q == RSQ_DELAY && core_tick && !dly_done) begin
                dly_cnt_q <= dly_cnt_q - CNT_W'(1);
            end
        end
    end

    // options frozen at the end of the active phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_q <= OPT_RST;
        end else if (clk_en && st_q == RSQ_ACTIVE) begin
            opt_q <= opt_s2;
        end
    end

    // two-cycle vector fetch; core reset released as it begins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fidx_q     <= 1'b0;
            core_rst_n <= 1'b0;
            vec_fetch  <= 1'b0;
            vec_addr   <= VEC_ADDR;
        end else if (clk_en) begin
            fidx_q     <= (st_d == RSQ_FETCH) && (st_q == RSQ_FETCH) && !fidx_q;
            core_rst_n <= (st_d == RSQ_FETCH) || (st_d == RSQ_RUN);
            vec_fetch  <= (st_d == RSQ_FETCH);
            vec_addr   <= VEC_ADDR | {15'h0000, (st_d == RSQ_FETCH) && (st_q == RSQ_FETCH)};
        end
    end

    assign wr_acc = psel && penable && pready && pwrite;

    // reset cause flags; hardware set beats a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_flag_q <= 1'b0;
            wdg_flag_q    <= 1'b0;
        end else if (clk_en) begin
            if (st_q != RSQ_ACTIVE && st_d == RSQ_ACTIVE && supply_low_q) begin
                supply_flag_q <= 1'b1;
                wdg_flag_q    <= 1'b0;
            end else if (st_q == RSQ_ACTIVE && supply_low_q) begin
                supply_flag_q <= 1'b1;
                wdg_flag_q    <= 1'b0;
            end else if (st_q == RSQ_RUN && wdg_underflow && !ext_req) begin
                wdg_flag_q    <= 1'b1;
            end else if (wr_acc && paddr == STATUS_OFS) begin
                supply_flag_q <= supply_flag_q & pwdata[SUPPLY_FLAG_BIT];
                wdg_flag_q    <= wdg_flag_q & pwdata[WDG_FLAG_BIT];
            end
        end
    end

    // apb: answer prepared in setup, one access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == STATUS_OFS || paddr == OPTION_OFS
                       || (paddr == SEQ_OFS && !pwrite));
            prdata  <= '0;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    STATUS_OFS: prdata <= {27'h0, supply_flag_q, 3'h0, wdg_flag_q};
                    OPTION_OFS: prdata <= {24'h0, opt_q};
                    SEQ_OFS:    prdata <= {27'h0, supply_low_q, 1'b0, st_q};
                    default:    prdata <= '0;
                endcase
            end
        end
    end

    // threshold select follows the strap; detector analog uses it live
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_sel <= 2'h0;
        end else if (clk_en) begin
            thr_sel <= opt_s2.thr;
        end
    end

    // clock source and multiplier from the frozen options
    rsq_clk_sel u_clk_sel (
        .pclk        (pclk),
        .presetn     (presetn),
        .clk_en      (clk_en),
        .opt         (opt_q),
        .osc_tick    (osc_tick),
        .osc_en_q    (osc_en),
        .mult_on_q   (mult_on),
        .mult_bad_q  (mult_bad),
        .core_tick_q (core_tick)
    );

    delay_pin_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == RSQ_ACTIVE || st_q == RSQ_DELAY) |-> rst_pin_oe && !rst_pin_o)
        else $error("reset pin released during active or delay phase");

    fetch_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && st_q == RSQ_FETCH && !fidx_q && !supply_low_q) |=> st_q == RSQ_FETCH && fidx_q)
        else $error("vector fetch did not reach second cycle");

    fetch_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && st_q == RSQ_FETCH && fidx_q && !supply_low_q) |=> st_q == RSQ_RUN)
        else $error("vector fetch longer than two cycles");

    vector_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        vec_fetch |-> vec_addr[15:1] == VEC_ADDR[15:1] && vec_addr[0] == fidx_q)
        else $error("vector fetch address wrong");

    core_release_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_rst_n == (st_q == RSQ_FETCH || st_q == RSQ_RUN))
        else $error("core reset not released at fetch");

    delay_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == RSQ_DELAY && $past(st_q) == RSQ_ACTIVE) |-> dly_cnt_q == delay_len(opt_q.delay_long))
        else $error("delay counter loaded with wrong length");

    stretch_min_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == RSQ_DELAY && $past(st_q) == RSQ_ACTIVE) |-> $past(act_cnt_q) == ACT_LAST)
        else $error("active phase shorter than minimum width");

    supply_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && supply_low_q) |=> rst_pin_oe && st_q == RSQ_ACTIVE)
        else $error("pin not held low during supply reset");

    flag_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && st_q == RSQ_RUN && supply_low_q) |=> supply_flag_q && !wdg_flag_q)
        else $error("supply reset flags wrong");

    det_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !opt_s2.det_en) |=> !supply_low_q)
        else $error("disabled detector produced reset");

    ext_reset_c: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == RSQ_RUN && ext_req ##1 st_q == RSQ_ACTIVE);
    wdg_reset_c: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == RSQ_RUN && wdg_underflow ##1 wdg_flag_q);
    supply_reset_c: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == RSQ_RUN && supply_low_q ##1 supply_flag_q);
    fetch_done_c: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == RSQ_FETCH && fidx_q ##1 st_q == RSQ_RUN);

endmodule // rsq_top
`default_nettype wire

// file: inc/rsq_pkg.sv
`default_nettype none
package rsq_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS      = 10;
    localparam int MIN_RST_OUT_NS     = 20000;
    localparam int MIN_RST_OUT_CYC    = (MIN_RST_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_SHORT_CYC    = 256;
    localparam int DELAY_LONG_CYC     = 4096;
    localparam int FETCH_CYC          = 2;
    localparam int CNT_W              = 13;

    // reset vector location
    localparam logic [15:0] VEC_ADDR  = 16'hfffe;

    // apb register map (byte addresses)
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] OPTION_OFS = 8'h04;
    localparam logic [7:0] SEQ_OFS    = 8'h08;

    // status field positions
    localparam int SUPPLY_FLAG_BIT    = 4;
    localparam int WDG_FLAG_BIT       = 0;

    // clock sources
    typedef enum logic [2:0] {
        RSQ_SRC_EXT,
        RSQ_SRC_RES0,
        RSQ_SRC_RES1,
        RSQ_SRC_RES2,
        RSQ_SRC_RES3,
        RSQ_SRC_RC
    } rsq_src_t;

    localparam int SRC_NUM            = 6;

    // supply detector threshold
    typedef enum logic [1:0] {
        RSQ_THR_LOW,
        RSQ_THR_MED,
        RSQ_THR_HIGH
    } rsq_thr_t;

    // option straps
    typedef struct packed {
        rsq_src_t src;
        logic     mult_en;
        logic     delay_long;
        logic     det_en;
        rsq_thr_t thr;
    } rsq_opt_t;

    localparam rsq_opt_t OPT_RST      = '{src: RSQ_SRC_EXT, mult_en: 1'b0, delay_long: 1'b1,
                                          det_en: 1'b0, thr: RSQ_THR_LOW};

    // sequencer states
    typedef enum logic [2:0] {
        RSQ_ACTIVE,
        RSQ_DELAY,
        RSQ_RELEASE,
        RSQ_FETCH,
        RSQ_RUN
    } rsq_state_t;

endpackage
`default_nettype wire

// file: hdl/rsq_clk_sel.sv
`timescale 1ns/100ps
`default_nettype none
module rsq_clk_sel
    import rsq_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               clk_en,
    input  wire rsq_opt_t           opt,
    input  wire logic               osc_tick,
    output logic [SRC_NUM-1:0]      osc_en_q,
    output logic                    mult_on_q,
    output logic                    mult_bad_q,
    output logic                    core_tick_q
);

    logic half_q;

    // one oscillator enabled, never gated by reset so no restart time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_en_q <= '0;
        end else if (clk_en) begin
            osc_en_q <= SRC_NUM'(1) << opt.src;
        end
    end

    // multiplier state; it is not meant for the rc source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_on_q  <= 1'b0;
            mult_bad_q <= 1'b0;
        end else if (clk_en) begin
            mult_on_q  <= opt.mult_en;
            mult_bad_q <= opt.mult_en && (opt.src == RSQ_SRC_RC);
        end
    end

    // core tick: every oscillator tick when doubled, every second one otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_q      <= 1'b0;
            core_tick_q <= 1'b0;
        end else if (clk_en) begin
            if (osc_tick) begin
                half_q <= !half_q;
            end
            core_tick_q <= osc_tick && (opt.mult_en || half_q);
        end
    end

endmodule // rsq_clk_sel
`default_nettype wire

// file: dv/rsq_ext_rst.sv
`timescale 1ns/100ps
`default_nettype none
// outside reset circuit plus other devices sharing the reset wire
module rsq_ext_rst (
    input  wire logic pull_low,
    input  wire logic rst_pin_o,
    input  wire logic rst_pin_oe,
    output logic      rst_pin_i
);
    // open drain with weak pull-up: any party pulling low wins
    assign rst_pin_i = !(pull_low || (rst_pin_oe && !rst_pin_o));
endmodule // rsq_ext_rst
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
    import rsq_pkg::*;
;
    logic               pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0, prdata, rd;
    logic               pready, pslverr, err, rst_pin_i, rst_pin_o, rst_pin_oe, mult_on, mult_bad;
    logic               core_tick, core_rst_n, vec_fetch, osc_tick = 1'h0, pull_low = 1'h1;
    logic               wdg_underflow = 1'h0, below_rise_i = 1'h0, below_fall_i = 1'h0;
    logic               clk_en = 1'h1;
    logic [1:0]         thr_sel;
    logic [SRC_NUM-1:0] osc_en;
    logic [15:0]        vec_addr;
    rsq_opt_t           opt_i = '{src: RSQ_SRC_RES1, mult_en: 1'h1, delay_long: 1'h0,
                                  det_en: 1'h1, thr: RSQ_THR_MED};
    int                 n_errors = 0, checked = 0, dly = 2 * DELAY_SHORT_CYC;

    rsq_top rsq_top_i (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rst_pin_i, .rst_pin_o, .rst_pin_oe, .wdg_underflow, .below_rise_i,
        .below_fall_i, .opt_i, .osc_tick, .thr_sel, .osc_en, .mult_on, .mult_bad,
        .core_tick, .core_rst_n, .vec_fetch, .vec_addr
    );
    rsq_ext_rst rsq_ext_rst_i (.pull_low, .rst_pin_o, .rst_pin_oe, .rst_pin_i);

    always #5 pclk = ~pclk;
    // oscillator at half the bus clock, so doubling is visible
    always @(posedge pclk) osc_tick <= ~osc_tick;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        // no local limit: only the watchdog may end a stalled wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wait_oe(input string what);
        int n;
        n = 0;
        while (rst_pin_oe !== 1'h1 && n < 8) begin
            @(posedge pclk);
            n++;
        end
        chk(what, 1'h1, rst_pin_oe);
    endtask

    // follow one sequence: pin span, optional hold by outside, two-cycle fetch
    task automatic run_seq(input int lo, input int hi);
        int n;
        n = 0;
        chk("core held in reset", 1'h0, core_rst_n);
        chk("resonator kept running", 6'h1 << opt_i.src, osc_en);
        while (rst_pin_oe === 1'h1 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        chk("pin low span in range", 1'h1, n >= lo && n <= hi);
        if (pull_low === 1'h1) begin
            repeat (40) begin
                @(posedge pclk);
                chk("no fetch while wire low", 1'h0, vec_fetch);
            end
            pull_low <= 1'h0;
        end
        n = 0;
        while (vec_fetch !== 1'h1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        chk("fetch address low", 16'hfffe, vec_addr);
        chk("core released at fetch", 1'h1, core_rst_n);
        @(posedge pclk);
        chk("fetch address high", 16'hffff, vec_addr);
        chk("fetch second cycle", 1'h1, vec_fetch);
        @(posedge pclk);
        chk("fetch over", 1'h0, vec_fetch);
    endtask

    task automatic count_ticks(input int exp);
        int n;
        n = 0;
        repeat (20) begin
            @(posedge pclk);
            if (core_tick === 1'h1) n++;
        end
        chk("core ticks in 20 cycles", exp, n);
    endtask

    task automatic t_power_on();
        // straps need two sync flops, the latch and the selector flop
        repeat (6) @(posedge pclk);
        chk("pin driven at power on", 1'h1, rst_pin_oe);
        chk("threshold select", RSQ_THR_MED, thr_sel);
        chk("multiplier on", 1'h1, mult_on);
        chk("multiplier misuse", 1'h0, mult_bad);
        run_seq(MIN_RST_OUT_CYC + dly - 16, MIN_RST_OUT_CYC + dly + 8);
        apb(1'h0, OPTION_OFS, 32'h0);
        chk("latched options", {24'h0, opt_i}, rd);
        count_ticks(10);
        $display("power-on test done");
    endtask

    task automatic t_external();
        @(posedge pclk);
        pull_low <= 1'h1;
        repeat (3) @(posedge pclk);
        pull_low <= 1'h0;
        wait_oe("short pulse caught");
        run_seq(MIN_RST_OUT_CYC + dly - 8, MIN_RST_OUT_CYC + dly + 8);
        apb(1'h0, STATUS_OFS, 32'h0);
        chk("flags after pin reset", 32'h0, rd);
        $display("external test done");
    endtask

    task automatic t_watchdog(input logic [31:0] status);
        @(posedge pclk);
        wdg_underflow <= 1'h1;
        @(posedge pclk);
        wdg_underflow <= 1'h0;
        wait_oe("watchdog drives pin");
        run_seq(MIN_RST_OUT_CYC + dly - 8, MIN_RST_OUT_CYC + dly + 8);
        apb(1'h0, STATUS_OFS, 32'h0);
        chk("flags after watchdog", status, rd);
        $display("watchdog test done");
    endtask

    // hysteresis: still held once only the upper comparator is low
    task automatic t_supply();
        @(posedge pclk);
        below_fall_i <= 1'h1;
        below_rise_i <= 1'h1;
        opt_i.mult_en <= 1'h0;
        wait_oe("supply drop drives pin");
        repeat (3000) @(posedge pclk);
        below_fall_i <= 1'h0;
        repeat (3000) @(posedge pclk);
        chk("held below upper threshold", 1'h1, rst_pin_oe);
        below_rise_i <= 1'h0;
        dly = 4 * DELAY_SHORT_CYC;
        run_seq(dly, MIN_RST_OUT_CYC + dly + 16);
        apb(1'h0, STATUS_OFS, 32'h0);
        chk("flags after supply drop", 32'h10, rd);
        chk("multiplier off", 1'h0, mult_on);
        count_ticks(5);
        $display("supply test done");
    endtask

    task automatic t_det_off();
        @(posedge pclk);
        opt_i.det_en <= 1'h0;
        repeat (4) @(posedge pclk);
        below_fall_i <= 1'h1;
        below_rise_i <= 1'h1;
        repeat (50) @(posedge pclk);
        chk("no reset with detector off", 1'h0, rst_pin_oe);
        below_fall_i <= 1'h0;
        below_rise_i <= 1'h0;
        repeat (5) @(posedge pclk);
        opt_i.det_en <= 1'h1;
        repeat (5) @(posedge pclk);
        $display("detector-off test done");
    endtask

    task automatic t_regs();
        apb(1'h0, 8'h0c, 32'h0);
        chk("unmapped read error", 1'h1, err);
        chk("unmapped read data", 32'h0, rd);
        apb(1'h1, SEQ_OFS, 32'hffffffff);
        chk("sequence write refused", 1'h1, err);
        apb(1'h0, SEQ_OFS, 32'h0);
        chk("sequence in run", 32'h4, rd);
        apb(1'h1, OPTION_OFS, 32'h0);
        apb(1'h0, OPTION_OFS, 32'h0);
        chk("options unchanged by write", {24'h0, opt_i}, rd);
        apb(1'h1, STATUS_OFS, 32'h0);
        apb(1'h0, STATUS_OFS, 32'h0);
        chk("flags cleared by zero", 32'h0, rd);
        $display("register test done");
    endtask

    // long delay with a frozen stretch; a clock that ran on would end 100 early
    task automatic t_long();
        @(posedge pclk);
        opt_i.delay_long <= 1'h1;
        opt_i.mult_en <= 1'h1;
        opt_i.thr <= RSQ_THR_HIGH;
        repeat (4) @(posedge pclk);
        chk("threshold select high", RSQ_THR_HIGH, thr_sel);
        pull_low <= 1'h1;
        repeat (3) @(posedge pclk);
        pull_low <= 1'h0;
        wait_oe("pin caught for long delay");
        clk_en <= 1'h0;
        repeat (100) @(posedge pclk);
        chk("pin held while frozen", 1'h1, rst_pin_oe);
        clk_en <= 1'h1;
        dly = 2 * DELAY_LONG_CYC;
        run_seq(MIN_RST_OUT_CYC + dly - 8, MIN_RST_OUT_CYC + dly + 8);
        apb(1'h0, OPTION_OFS, 32'h0);
        chk("latched long option", {24'h0, opt_i}, rd);
        count_ticks(10);
        $display("long delay test done");
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        t_power_on();
        t_external();
        t_watchdog(32'h1);
        t_supply();
        t_watchdog(32'h11);
        t_det_off();
        t_regs();
        t_long();
        finish_test();
    end

    // whole run is near 30k cycles; cut a hang well after that
    initial begin
        #600us;
        n_errors++;
        $display("CHECK FAILED run time expected finish seen timeout");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
